// *** src/bau_arith_unit.sv ***
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - add immediate to working register, result there, all four flags.
// - memory plus working register into either operand, all four flags.
// - memory plus working register plus carry into either, all flags.
// - add carry alone to working register or memory byte, in place.
// - working register gets memory minus working register, all flags.
// - memory gets working register minus memory, all flags.
// - working register minus immediate via two's complement add, all flags.
// - working register minus memory into working register, all flags.
// - memory minus working register into memory, all flags.
// - working register minus memory minus carry into working register.
// - memory minus working register minus carry into memory.
// - subtract carry alone from working register or memory, in place.
// - increment memory byte, write back, update all four flags.
// - decrement memory byte, write back, update all four flags.
// - clear writes zero to memory byte, flags untouched.
// - unsigned 8x8 multiply, high byte to product-high, low to working.
module bau_arith_unit
    import bau_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [BE_W-1:0]   avs_byteenable,
    input  wire logic [DATA_W-1:0] avs_writedata,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest
);

    // architectural state
    logic [BYTE_W-1:0] working_register;
    logic [BYTE_W-1:0] mul_operand;
    logic [BYTE_W-1:0] product_high;
    logic [BYTE_W-1:0] mem_byte;
    logic [BYTE_W-1:0] imm_byte;
    logic [FLAG_W-1:0] flags;
    logic [OP_W-1:0]   last_op;

    // bus decode
    logic              req;
    logic              wr_go;
    logic              rd_go;
    logic              be_low;
    logic              sel_work;
    logic              sel_flags;
    logic              sel_mulop;
    logic              sel_prodhi;
    logic              sel_mem;
    logic              sel_imm;
    logic              sel_cmd;
    logic [DATA_W-1:0] rd_mux;

    // command decode
    bau_op_e           cmd_op;
    logic              exec;
    logic              d_x_mem;
    logic [1:0]        d_y_sel;
    logic              d_sub;
    logic [1:0]        d_c_sel;
    logic              d_dst_mem;
    logic              d_upd;
    logic              d_valid;
    logic              d_clear;
    logic              d_mul;

    // datapath
    logic [BYTE_W-1:0]   op_x;
    logic [BYTE_W-1:0]   op_y;
    logic                op_c;
    logic [BYTE_W-1:0]   alu_sum;
    logic [FLAG_W-1:0]   alu_flags;
    logic [2*BYTE_W-1:0] product;

    // next values
    logic [BYTE_W-1:0] next_working_register;
    logic [BYTE_W-1:0] next_mul_operand;
    logic [BYTE_W-1:0] next_product_high;
    logic [BYTE_W-1:0] next_mem_byte;
    logic [BYTE_W-1:0] next_imm_byte;
    logic [FLAG_W-1:0] next_flags;
    logic [OP_W-1:0]   next_last_op;

    // one wait state per access: a write is taken on the edge at which
    // waitrequest is seen low; read data is captured one edge earlier
    assign req    = avs_read | avs_write;
    assign wr_go  = avs_write & ~avs_waitrequest;
    assign rd_go  = avs_read & ~avs_waitrequest;
    assign be_low = avs_byteenable[0];

    // address decode; misaligned or unlisted addresses hit nothing
    assign sel_work   = (avs_address == OFF_WORK);
    assign sel_flags  = (avs_address == OFF_FLAGS);
    assign sel_mulop  = (avs_address == OFF_MULOP);
    assign sel_prodhi = (avs_address == OFF_PRODHI);
    assign sel_mem    = (avs_address == OFF_MEM);
    assign sel_imm    = (avs_address == OFF_IMM);
    assign sel_cmd    = (avs_address == OFF_CMD);

    // read mux; bytes sit in the low lane, upper bits and holes read zero
    assign rd_mux =
        sel_work   ? {{(DATA_W-BYTE_W){1'b0}}, working_register} :
        sel_flags  ? {{(DATA_W-FLAG_W){1'b0}}, flags} :
        sel_mulop  ? {{(DATA_W-BYTE_W){1'b0}}, mul_operand} :
        sel_prodhi ? {{(DATA_W-BYTE_W){1'b0}}, product_high} :
        sel_mem    ? {{(DATA_W-BYTE_W){1'b0}}, mem_byte} :
        sel_imm    ? {{(DATA_W-BYTE_W){1'b0}}, imm_byte} :
        sel_cmd    ? {{(DATA_W-OP_W){1'b0}}, last_op} :
                     {DATA_W{1'b0}};

    // a command runs in the same edge as its write completes
    assign cmd_op = bau_op_e'(avs_writedata[OP_W-1:0]);
    assign exec   = wr_go & sel_cmd & be_low;

    // per-command operand steering
    always_comb begin
        d_x_mem   = 1'b0;
        d_y_sel   = Y_ZERO;
        d_sub     = 1'b0;
        d_c_sel   = C_ZERO;
        d_dst_mem = 1'b0;
        d_upd     = 1'b1;
        d_valid   = 1'b1;
        d_clear   = 1'b0;
        d_mul     = 1'b0;
        case (cmd_op)
            OP_ADD_IMM: begin
                d_y_sel = Y_IMM;
            end
            OP_ADD_A_M: begin
                d_y_sel = Y_MEM;
            end
            OP_ADD_M_A: begin
                d_y_sel   = Y_MEM;
                d_dst_mem = 1'b1;
            end
            OP_ADDC_A_M: begin
                d_y_sel = Y_MEM;
                d_c_sel = C_FLAG;
            end
            OP_ADDC_M_A: begin
                d_y_sel   = Y_MEM;
                d_c_sel   = C_FLAG;
                d_dst_mem = 1'b1;
            end
            OP_ADDC_A: begin
                d_c_sel = C_FLAG;
            end
            OP_ADDC_M: begin
                d_x_mem   = 1'b1;
                d_c_sel   = C_FLAG;
                d_dst_mem = 1'b1;
            end
            OP_NADD_A_M: begin
                d_x_mem = 1'b1;
                d_y_sel = Y_WORK;
                d_sub   = 1'b1;
            end
            OP_NADD_M_A: begin
                d_y_sel   = Y_MEM;
                d_sub     = 1'b1;
                d_dst_mem = 1'b1;
            end
            OP_SUB_IMM: begin
                d_y_sel = Y_IMM;
                d_sub   = 1'b1;
            end
            OP_SUB_A_M: begin
                d_y_sel = Y_MEM;
                d_sub   = 1'b1;
            end
            OP_SUB_M_A: begin
                d_x_mem   = 1'b1;
                d_y_sel   = Y_WORK;
                d_sub     = 1'b1;
                d_dst_mem = 1'b1;
            end
            OP_SUBC_A_M: begin
                d_y_sel = Y_MEM;
                d_sub   = 1'b1;
                d_c_sel = C_FLAG;
            end
            OP_SUBC_M_A: begin
                d_x_mem   = 1'b1;
                d_y_sel   = Y_WORK;
                d_sub     = 1'b1;
                d_c_sel   = C_FLAG;
                d_dst_mem = 1'b1;
            end
            OP_SUBC_A: begin
                d_sub   = 1'b1;
                d_c_sel = C_FLAG;
            end
            OP_SUBC_M: begin
                d_x_mem   = 1'b1;
                d_sub     = 1'b1;
                d_c_sel   = C_FLAG;
                d_dst_mem = 1'b1;
            end
            OP_INC_M: begin
                d_x_mem   = 1'b1;
                d_c_sel   = C_ONE;
                d_dst_mem = 1'b1;
            end
            OP_DEC_M: begin
                d_x_mem   = 1'b1;
                d_sub     = 1'b1;
                d_c_sel   = C_ONE;
                d_dst_mem = 1'b1;
            end
            OP_CLEAR_M: begin
                d_clear = 1'b1;
                d_upd   = 1'b0;
            end
            OP_MUL: begin
                d_mul = 1'b1;
                d_upd = 1'b0;
            end
            default: begin
                d_valid = 1'b0;
                d_upd   = 1'b0;
            end
        endcase
    end

    // operand muxes; inc and dec reuse the carry-in as the constant one
    assign op_x = d_x_mem ? mem_byte : working_register;
    assign op_y = (d_y_sel == Y_WORK) ? working_register :
                  (d_y_sel == Y_MEM)  ? mem_byte :
                  (d_y_sel == Y_IMM)  ? imm_byte : RST_BYTE;
    assign op_c = (d_c_sel == C_FLAG) ? flags[FLAG_CARRY] :
                  (d_c_sel == C_ONE);

    bau_adder u_adder (
        .x                  (op_x),
        .y                  (op_y),
        .cin                (op_c),
        .sub                (d_sub),
        .sum                (alu_sum),
        .zero               (alu_flags[FLAG_ZERO]),
        .carry              (alu_flags[FLAG_CARRY]),
        .nibble_carry       (alu_flags[FLAG_NIB]),
        .signed_range_fault (alu_flags[FLAG_SRF])
    );

    // unsigned product, both halves land in one edge
    assign product = working_register * mul_operand;

    // software writes and command results never collide: one access at a time
    assign next_working_register =
        (wr_go && sel_work && be_low)  ? avs_writedata[BYTE_W-1:0] :
        (exec && d_mul)                ? product[BYTE_W-1:0] :
        (exec && d_upd && !d_dst_mem)  ? alu_sum :
                                         working_register;
    assign next_mem_byte =
        (wr_go && sel_mem && be_low)   ? avs_writedata[BYTE_W-1:0] :
        (exec && d_clear)              ? RST_BYTE :
        (exec && d_upd && d_dst_mem)   ? alu_sum :
                                         mem_byte;
    assign next_product_high =
        (wr_go && sel_prodhi && be_low) ? avs_writedata[BYTE_W-1:0] :
        (exec && d_mul)                 ? product[2*BYTE_W-1:BYTE_W] :
                                          product_high;
    assign next_flags =
        (wr_go && sel_flags && be_low) ? avs_writedata[FLAG_W-1:0] :
        (exec && d_upd)                ? alu_flags :
                                         flags;
    assign next_mul_operand = (wr_go && sel_mulop && be_low)
                            ? avs_writedata[BYTE_W-1:0] : mul_operand;
    assign next_imm_byte    = (wr_go && sel_imm && be_low)
                            ? avs_writedata[BYTE_W-1:0] : imm_byte;
    // an unknown code is dropped but still recorded, so software can see it
    assign next_last_op     = exec ? avs_writedata[OP_W-1:0] : last_op;

    // bus handshake: answer one edge after the request is seen
    always_ff @(posedge clock) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= {DATA_W{1'b0}};
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            avs_readdata    <= (avs_read && avs_waitrequest) ? rd_mux
                                                             : avs_readdata;
        end
    end

    // datapath registers
    always_ff @(posedge clock) begin
        if (rst) begin
            working_register <= RST_BYTE;
            mem_byte         <= RST_BYTE;
            product_high     <= RST_BYTE;
            mul_operand      <= RST_BYTE;
            imm_byte         <= RST_BYTE;
            flags            <= RST_FLAGS;
            last_op          <= RST_OP;
        end else begin
            working_register <= next_working_register;
            mem_byte         <= next_mem_byte;
            product_high     <= next_product_high;
            mul_operand      <= next_mul_operand;
            imm_byte         <= next_imm_byte;
            flags            <= next_flags;
            last_op          <= next_last_op;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    bus_answer_a: assert property (
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("slave did not answer after one wait state");

    add_imm_a: assert property (
        exec && cmd_op == OP_ADD_IMM |=>
        working_register == 8'($past(working_register) + $past(imm_byte)))
        else $error("add immediate result wrong");

    addc_work_a: assert property (
        exec && cmd_op == OP_ADDC_A_M |=>
        working_register == 8'($past(working_register) + $past(mem_byte)
                               + {7'h00, $past(flags[FLAG_CARRY])}))
        else $error("add with carry result wrong");

    sub_borrow_a: assert property (
        exec && cmd_op == OP_SUB_IMM |=>
        flags[FLAG_CARRY] == ($past(working_register) < $past(imm_byte)))
        else $error("subtract borrow flag wrong");

    subc_mem_a: assert property (
        exec && cmd_op == OP_SUBC_M_A |=>
        mem_byte == 8'($past(mem_byte) - $past(working_register)
                       - {7'h00, $past(flags[FLAG_CARRY])})
        && working_register == $past(working_register))
        else $error("memory subtract with borrow wrong");

    inc_mem_a: assert property (
        exec && cmd_op == OP_INC_M |=>
        mem_byte == 8'($past(mem_byte) + 8'h01)
        && flags[FLAG_CARRY] == ($past(mem_byte) == 8'hff))
        else $error("increment wrong");

    dec_mem_a: assert property (
        exec && cmd_op == OP_DEC_M |=>
        mem_byte == 8'($past(mem_byte) - 8'h01)
        && flags[FLAG_CARRY] == ($past(mem_byte) == 8'h00))
        else $error("decrement wrong");

    clear_keep_a: assert property (
        exec && cmd_op == OP_CLEAR_M |=>
        mem_byte == RST_BYTE && $stable(flags))
        else $error("clear changed flags or left data");

    mul_split_a: assert property (
        exec && cmd_op == OP_MUL |=>
        {product_high, working_register}
            == 16'($past(working_register) * $past(mul_operand))
        && $stable(flags))
        else $error("multiply result wrong");

    zero_flag_a: assert property (
        exec && d_upd && !d_dst_mem |=>
        flags[FLAG_ZERO] == (working_register == RST_BYTE))
        else $error("zero flag disagrees with result");

endmodule

`default_nettype wire

// *** inc/bau_pkg.sv ***
package bau_pkg;

    // bus and datapath widths
    localparam int BYTE_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int BE_W   = 4;
    localparam int OP_W   = 5;
    localparam int FLAG_W = 4;
    localparam int NIB_W  = 4;

    // register byte offsets on the slave port
    localparam logic [ADDR_W-1:0] OFF_WORK   = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_FLAGS  = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_MULOP  = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_PRODHI = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_MEM    = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_IMM    = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_CMD    = 5'h18;

    // bit positions inside the flag register
    localparam int FLAG_ZERO  = 0;
    localparam int FLAG_CARRY = 1;
    localparam int FLAG_NIB   = 2;
    localparam int FLAG_SRF   = 3;

    // reset values
    localparam logic [BYTE_W-1:0] RST_BYTE  = 8'h00;
    localparam logic [FLAG_W-1:0] RST_FLAGS = 4'h0;
    localparam logic [OP_W-1:0]   RST_OP    = 5'h1f;

    // second operand select
    localparam logic [1:0] Y_ZERO = 2'h0;
    localparam logic [1:0] Y_WORK = 2'h1;
    localparam logic [1:0] Y_MEM  = 2'h2;
    localparam logic [1:0] Y_IMM  = 2'h3;

    // carry-in select (for subtracts this is the borrow-in)
    localparam logic [1:0] C_ZERO = 2'h0;
    localparam logic [1:0] C_FLAG = 2'h1;
    localparam logic [1:0] C_ONE  = 2'h2;

    // command codes written into the command register
    typedef enum logic [OP_W-1:0] {
        OP_ADD_IMM,
        OP_ADD_A_M,
        OP_ADD_M_A,
        OP_ADDC_A_M,
        OP_ADDC_M_A,
        OP_ADDC_A,
        OP_ADDC_M,
        OP_NADD_A_M,
        OP_NADD_M_A,
        OP_SUB_IMM,
        OP_SUB_A_M,
        OP_SUB_M_A,
        OP_SUBC_A_M,
        OP_SUBC_M_A,
        OP_SUBC_A,
        OP_SUBC_M,
        OP_INC_M,
        OP_DEC_M,
        OP_CLEAR_M,
        OP_MUL
    } bau_op_e;

endpackage

// *** src/bau_adder.sv ***
`timescale 1ns/1ns
`default_nettype none

// one 8-bit adder serves adds and subtracts; subtracts invert the second
// operand and the carry sense so borrows come out directly
module bau_adder
    import bau_pkg::*;
(
    input  wire logic [BYTE_W-1:0] x,
    input  wire logic [BYTE_W-1:0] y,
    input  wire logic              cin,
    input  wire logic              sub,
    output logic      [BYTE_W-1:0] sum,
    output logic                   zero,
    output logic                   carry,
    output logic                   nibble_carry,
    output logic                   signed_range_fault
);

    logic [BYTE_W-1:0] y_eff;
    logic              cin_eff;
    logic [BYTE_W:0]   full;
    logic [NIB_W:0]    low;

    // x - y - b is x + ~y + !b
    assign y_eff   = sub ? ~y : y;
    assign cin_eff = sub ? ~cin : cin;
    assign full    = {1'b0, x} + {1'b0, y_eff} + {{BYTE_W{1'b0}}, cin_eff};
    assign low     = {1'b0, x[NIB_W-1:0]} + {1'b0, y_eff[NIB_W-1:0]}
                   + {{NIB_W{1'b0}}, cin_eff};

    // flags: carry/borrow out of bit 7 and bit 3, signed overflow
    assign sum                = full[BYTE_W-1:0];
    assign zero               = (full[BYTE_W-1:0] == RST_BYTE);
    assign carry              = sub ? ~full[BYTE_W] : full[BYTE_W];
    assign nibble_carry       = sub ? ~low[NIB_W] : low[NIB_W];
    assign signed_range_fault = (x[BYTE_W-1] == y_eff[BYTE_W-1])
                              && (full[BYTE_W-1] != x[BYTE_W-1]);

endmodule

`default_nettype wire

// *** bench/bau_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// bus master standing in for the core's decoder; one access at a time
module bau_host_model
    import bau_pkg::*;
(
    input  wire logic              clock,
    input  wire logic [DATA_W-1:0] avs_readdata,
    input  wire logic              avs_waitrequest,
    output logic      [ADDR_W-1:0] avs_address,
    output logic                   avs_read,
    output logic                   avs_write,
    output logic      [BE_W-1:0]   avs_byteenable,
    output logic      [DATA_W-1:0] avs_writedata,
    output logic                   hung
);
    // idle bus at time zero
    initial begin
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_byteenable = '0;
        avs_writedata  = '0;
        hung           = 1'b0;
    end

    // request held until waitrequest is seen low; one edge of idle after
    // release so a following call never assigns twice in one time step
    task automatic xfer(input logic              wr,
                        input logic [ADDR_W-1:0] adr,
                        input logic [DATA_W-1:0] wd,
                        input logic [BE_W-1:0]   be,
                        output logic [DATA_W-1:0] rd);
        int k;
        k = 0;
        avs_address    <= adr;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 64);
        rd = avs_readdata;
        if (k >= 64) hung <= 1'b1;
        avs_read       <= 1'b0;
        avs_write      <= 1'b0;
        avs_address    <= ~adr;     // released address and data never keep old value
        avs_writedata  <= ~wd;
        @(posedge clock);
    endtask
endmodule

`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("BAD t=%0t got %h exp %h", $time, g, e); \
    end \
end

module tb
    import bau_pkg::*;
;
    // per command: x is memory, y select, carry select, subtract, to memory
    localparam logic [6:0] TBL [18] = '{7'h30, 7'h20, 7'h51, 7'h24, 7'h55,
        7'h04, 7'h45, 7'h52, 7'h23, 7'h32, 7'h22, 7'h53, 7'h26, 7'h57,
        7'h06, 7'h47, 7'h49, 7'h4b};

    logic              clock;
    logic              rst;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [BE_W-1:0]   avs_byteenable;
    logic [DATA_W-1:0] avs_writedata;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              hung;
    int                n_errors;
    int                tests_run;
    int                cycles = 0;
    int                seed;
    logic [BYTE_W-1:0] ma, mm, mi, mo, mp;
    logic [FLAG_W-1:0] mf;
    logic [OP_W-1:0]   mc;
    logic [DATA_W-1:0] rdv;

    bau_host_model host (
        .clock           (clock),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_byteenable  (avs_byteenable),
        .avs_writedata   (avs_writedata),
        .hung            (hung)
    );

    bau_arith_unit dut (
        .clock           (clock),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_byteenable  (avs_byteenable),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest)
    );

    // expected effect of one command on the model registers
    function automatic void calc(input logic [OP_W-1:0] op);
        logic [6:0] e;
        logic [7:0] x, y;
        logic       b, cc;
        logic [8:0] t;
        logic [4:0] n;
        logic [7:0] l;
        if (op == OP_CLEAR_M) mm = 8'h00;
        if (op == OP_MUL) {mp, ma} = ma * mo;
        if (op > OP_DEC_M) return;
        e = TBL[op];
        x = e[6] ? mm : ma;
        y = (e[5:4] == 2'h1) ? ma : (e[5:4] == 2'h2) ? mm :
            (e[5:4] == 2'h3) ? mi : 8'h00;
        b = (e[3:2] == 2'h1) ? mf[FLAG_CARRY] : (e[3:2] == 2'h2);
        y = e[1] ? ~y : y;      // subtracts add the inverse, borrow inverted
        cc = e[1] ? !b : b;
        t = x + y + cc;
        n = x[3:0] + y[3:0] + cc;
        l = x[6:0] + y[6:0] + cc;
        mf = {l[7] ^ t[8], n[4] ^ e[1], t[8] ^ e[1], t[7:0] == 8'h00};
        if (e[0]) mm = t[7:0];
        else ma = t[7:0];
    endfunction

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, 4'hf, rdv);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        host.xfer(1'b0, a, 32'h0, 4'h0, rdv);
    endtask

    task automatic load(input logic [7:0] a, m, i, o, p,
                        input logic [3:0] f);
        ma = a;
        mm = m;
        mi = i;
        mo = o;
        mp = p;
        mf = f;
        wr(OFF_WORK, a);
        wr(OFF_MEM, m);
        wr(OFF_IMM, i);
        wr(OFF_MULOP, o);
        wr(OFF_PRODHI, p);
        wr(OFF_FLAGS, {4'h0, f});
    endtask

    // read back all registers but the multiply operand and immediate against the model
    task automatic readback();
        rd(OFF_WORK);
        `CHK(rdv, {24'h0, ma})
        rd(OFF_MEM);
        `CHK(rdv, {24'h0, mm})
        rd(OFF_FLAGS);
        `CHK(rdv, {28'h0, mf})
        rd(OFF_PRODHI);
        `CHK(rdv, {24'h0, mp})
        rd(OFF_CMD);
        `CHK(rdv, {27'h0, mc})
    endtask

    task automatic step(input logic [OP_W-1:0] op);
        wr(OFF_CMD, {3'h0, op});
        calc(op);
        mc = op;
        readback();
    endtask

    task automatic rload();
        load($random(seed), $random(seed), $random(seed), $random(seed),
             $random(seed), $random(seed));
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // a hung handshake or a run far past its budget ends the run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000 || hung === 1'b1) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        seed = 95;
        n_errors = 0;
        tests_run = 0;
        rst = 1'b1;
        {ma, mm, mi, mo, mp, mf} = '0;
        mc = RST_OP;
        repeat (4) @(posedge clock);
        `CHK(avs_waitrequest, 1'b1)
        `CHK(avs_readdata, 32'h0)
        rst <= 1'b0;
        @(posedge clock);
        // reset values, unmapped and misaligned places read zero
        for (int a = 0; a < 32; a++) begin
            rd(a[ADDR_W-1:0]);
            `CHK(rdv, (a == OFF_CMD) ? {27'h0, RST_OP} : 32'h0)
        end
        // writes to unmapped places or with lane 0 off change nothing
        rload();
        wr(5'h1c, 8'hff);
        wr(5'h01, 8'hff);
        wr(5'h11, 8'hff);
        host.xfer(1'b1, OFF_WORK, 32'h55, 4'he, rdv);
        readback();
        // hand-picked boundaries
        load(8'h7f, 8'h00, 8'h01, 8'h00, 8'h00, 4'h0);
        step(OP_ADD_IMM);
        load(8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 4'h0);
        step(OP_INC_M);
        step(OP_DEC_M);
        step(OP_DEC_M);
        load(8'ha5, 8'h00, 8'h00, 8'h5a, 8'h00, 4'hf);
        step(OP_MUL);
        load(8'h00, 8'h5a, 8'h00, 8'h00, 8'h00, 4'ha);
        step(OP_CLEAR_M);
        load(8'h00, 8'h80, 8'h10, 8'h00, 8'h00, 4'h2);
        step(OP_SUBC_A);
        step(OP_SUBC_M);
        step(OP_SUB_IMM);
        // every code once, then random chains sharing the carry flag
        for (int op = 0; op < 32; op++) begin
            rload();
            step(op[OP_W-1:0]);
        end
        repeat (250) begin
            if ($random(seed) & 1) rload();
            step($random(seed));
        end
        summarize();
    end
endmodule

`default_nettype wire
